//--- src/scc_consts.vh
// Constants for the smart card contact and status register bank.
// Included by the contact and status design file by bare name; definitions only.
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// Register indices; byte address is four times the index
`define SCC_IDX_CONTACT 8'hac
`define SCC_IDX_STATUS 8'had
`define SCC_IDX_AUX 8'hb0

// Reset values
`define SCC_RST_CONTACT 8'h00
`define SCC_RST_STATUS 8'h80
`define SCC_RST_AUX 8'h00

// Contact register fields
`define SCC_CON_CLKSEL 7
`define SCC_CON_RSVD 6
`define SCC_CON_C8 5
`define SCC_CON_C4 4
`define SCC_CON_IO 3
`define SCC_CON_CLK 2
`define SCC_CON_RST 1
`define SCC_CON_PWR 0

// Status register fields
`define SCC_ST_TBE 7
`define SCC_ST_PRES 6
`define SCC_ST_OVER 5
`define SCC_ST_VOK 4
`define SCC_ST_WTO 3
`define SCC_ST_SENT 2
`define SCC_ST_RCVD 1
`define SCC_ST_PE 0

// Auxiliary control fields
`define SCC_AUX_UART 3
`define SCC_AUX_REP 1

// Parity error indications on the line before the flag is raised
`define SCC_PE_LIMIT 2'h3

`endif

//--- src/scc_clk_sel.v
// Glitch-free selector between the software clock bit and the crystal level.
// Assumes both source levels are already in the i_mclk domain.
`timescale 1ns/100ps

module scc_clk_sel (
   // Clock, reset, enable
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_ce,
   // Sources and select
   input wire i_sel,
   input wire i_soft_clk,
   input wire i_crystal_clock_lvl,
   // Selected clock level
   output reg o_clk
);

localparam ST_RUN = 1'b0;
localparam ST_PARK = 1'b1;

reg state_r;
reg cur_sel_r;
wire cur_src;
wire new_src;

assign cur_src = cur_sel_r ? i_crystal_clock_lvl : i_soft_clk;
assign new_src = i_sel ? i_crystal_clock_lvl : i_soft_clk;

////////////////////////////////////////////////////////////////////////////////
// Park low on the old source, resume on a low phase of the new one
always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      state_r <= ST_RUN;
      cur_sel_r <= 1'b0;
      o_clk <= 1'b0;
   end else if (i_ce) begin
      case (state_r)
         ST_RUN: begin
            if ((i_sel != cur_sel_r) && !cur_src) begin
               state_r <= ST_PARK;
               o_clk <= 1'b0;
            end else begin
               o_clk <= cur_src;
            end
         end
         ST_PARK: begin
            o_clk <= 1'b0;
            cur_sel_r <= i_sel;
            if (!new_src) begin
               state_r <= ST_RUN;
            end
         end
         default: begin
            state_r <= ST_RUN;
            o_clk <= 1'b0;
         end
      endcase
   end
end

endmodule // scc_clk_sel

//--- src/scc_contact_status.v
// Smart card contact control and interface status registers, Avalon-MM slave.
// Assumes UART event inputs are on i_mclk; card pins and crystal are asynchronous.
`timescale 1ns/100ps
`include "scc_consts.vh"

module scc_contact_status (
   // Clock, reset, enable
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_ce,
   // Avalon-MM slave
   input wire [9:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // Card UART events, same clock
   input wire i_tx_load,
   input wire i_txbuf_wr,
   input wire i_tx_done,
   input wire i_rx_done,
   input wire i_rx_buf_rd,
   input wire i_rx_parity_err,
   input wire i_rx_mode,
   input wire i_uart_io_out,
   input wire i_wt_timeout,
   input wire i_wt_reload,
   output reg o_pe_indicate,
   output reg o_uart_sel,
   // Asynchronous analog and detect inputs
   input wire i_card_detect,
   input wire i_icc_over,
   input wire i_vcc_in_range,
   input wire i_crystal_clock_clk,
   // Card pins
   output reg o_card_power,
   output reg o_card_clk,
   output reg o_card_rst,
   output reg o_card_c4,
   output reg o_card_c8,
   input wire i_card_io,
   output reg o_card_io_out,
   output reg o_card_io_oe
);

////////////////////////////////////////////////////////////////////////////////
// Decode helpers

function hit;
   input [9:0] addr;
   input [7:0] idx;
   begin
      hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers

reg [1:0] det_s_r;
reg [1:0] over_s_r;
reg [1:0] vok_s_r;
reg [1:0] crystal_clock_s_r;
reg [1:0] io_s_r;

always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      det_s_r <= 2'h0;
      over_s_r <= 2'h0;
      vok_s_r <= 2'h0;
   end else if (i_ce) begin
      det_s_r <= {det_s_r[0], i_card_detect};
      over_s_r <= {over_s_r[0], i_icc_over};
      vok_s_r <= {vok_s_r[0], i_vcc_in_range};
   end
end

// Crystal level for the card clock selector
always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      crystal_clock_s_r <= 2'h0;
   end else if (i_ce) begin
      crystal_clock_s_r <= {crystal_clock_s_r[0], i_crystal_clock_clk};
   end
end

// Resets low: the line is pulled down while power is off
always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      io_s_r <= 2'h0;
   end else if (i_ce) begin
      io_s_r <= {io_s_r[0], i_card_io};
   end
end

////////////////////////////////////////////////////////////////////////////////
// Bus handshake: one wait state per access

reg [7:0] contact_r;
reg [7:0] aux_r;
reg tbe_r;
reg wto_r;
reg sent_r;
reg rcvd_r;
reg pe_r;
reg [1:0] pe_cnt_r;

wire req;
wire wr_go;
wire wr_contact;
wire wr_status;
wire wr_aux;
wire io_read;
wire [7:0] contact_rd;
wire [7:0] status_rd;
reg [7:0] rd_byte;

assign req = i_avs_read | i_avs_write;
assign wr_go = i_avs_write & ~o_avs_waitrequest;
assign wr_contact = wr_go & hit(i_avs_address, `SCC_IDX_CONTACT);
assign wr_status = wr_go & hit(i_avs_address, `SCC_IDX_STATUS);
assign wr_aux = wr_go & hit(i_avs_address, `SCC_IDX_AUX);

assign io_read = aux_r[`SCC_AUX_UART] ? contact_r[`SCC_CON_IO] : io_s_r[1];
assign contact_rd = {contact_r[`SCC_CON_CLKSEL], 1'b0, contact_r[`SCC_CON_C8],
   contact_r[`SCC_CON_C4], io_read, contact_r[`SCC_CON_CLK],
   contact_r[`SCC_CON_RST], contact_r[`SCC_CON_PWR]};
assign status_rd = {tbe_r, det_s_r[1], over_s_r[1], vok_s_r[1],
   wto_r, sent_r, rcvd_r, pe_r};

always @* begin
   rd_byte = 8'h00;
   if (hit(i_avs_address, `SCC_IDX_CONTACT)) begin
      rd_byte = contact_rd;
   end else if (hit(i_avs_address, `SCC_IDX_STATUS)) begin
      rd_byte = status_rd;
   end else if (hit(i_avs_address, `SCC_IDX_AUX)) begin
      rd_byte = aux_r;
   end
end

always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
   end else if (i_ce) begin
      if (req && o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'b0;
         o_avs_readdata <= {24'h000000, rd_byte};
      end else begin
         o_avs_waitrequest <= 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      contact_r <= `SCC_RST_CONTACT;
      aux_r <= `SCC_RST_AUX;
   end else if (i_ce) begin
      if (wr_contact) begin
         contact_r <= i_avs_writedata[7:0] & 8'hbf;
      end
      if (wr_aux) begin
         aux_r <= i_avs_writedata[7:0] & 8'h0a;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Status flags; a hardware set wins over a clear in the same cycle

wire [7:0] rst_status;
wire clr_sent;
wire clr_pe;
wire pe_repeat;

// Status writes clear sent and parity flags on zero bits
assign rst_status = `SCC_RST_STATUS;
assign clr_sent = wr_status & ~i_avs_writedata[`SCC_ST_SENT];
assign clr_pe = wr_status & ~i_avs_writedata[`SCC_ST_PE];
assign pe_repeat = i_rx_mode & aux_r[`SCC_AUX_REP] & (pe_cnt_r != `SCC_PE_LIMIT);

always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      tbe_r <= rst_status[`SCC_ST_TBE];
      wto_r <= 1'b0;
      sent_r <= 1'b0;
      rcvd_r <= 1'b0;
      pe_r <= 1'b0;
      pe_cnt_r <= 2'h0;
      o_pe_indicate <= 1'b0;
   end else if (i_ce) begin
      if (i_tx_load) begin
         tbe_r <= 1'b1;
      end else if (i_txbuf_wr) begin
         tbe_r <= 1'b0;
      end
      if (i_wt_timeout) begin
         wto_r <= 1'b1;
      end else if (i_wt_reload) begin
         wto_r <= 1'b0;
      end
      if (i_tx_done) begin
         sent_r <= 1'b1;
      end else if (clr_sent) begin
         sent_r <= 1'b0;
      end
      if (i_rx_done) begin
         rcvd_r <= 1'b1;
      end else if (i_rx_buf_rd) begin
         rcvd_r <= 1'b0;
      end
      o_pe_indicate <= 1'b0;
      // Clear first so a same-cycle error still sets the flag
      if (clr_pe) begin
         pe_r <= 1'b0;
      end
      if (i_rx_done && i_rx_parity_err) begin
         if (pe_repeat) begin
            pe_cnt_r <= pe_cnt_r + 2'h1;
            o_pe_indicate <= 1'b1;
         end else begin
            pe_cnt_r <= 2'h0;
            pe_r <= 1'b1;
         end
      end else if (i_rx_done) begin
         pe_cnt_r <= 2'h0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Card clock source selection

wire sel_clk;

scc_clk_sel u_clk_sel (
   .i_mclk(i_mclk),
   .i_rst_n(i_rst_n),
   .i_ce(i_ce),
   .i_sel(contact_r[`SCC_CON_CLKSEL]),
   .i_soft_clk(contact_r[`SCC_CON_CLK]),
   .i_crystal_clock_lvl(crystal_clock_s_r[1]),
   .o_clk(sel_clk)
);

////////////////////////////////////////////////////////////////////////////////
// Card pins, all gated by the power bit

wire pwr;
wire io_src;

assign pwr = contact_r[`SCC_CON_PWR];
assign io_src = aux_r[`SCC_AUX_UART] ? i_uart_io_out : contact_r[`SCC_CON_IO];

always @(posedge i_mclk) begin
   if (!i_rst_n) begin
      o_card_power <= 1'b0;
      o_card_clk <= 1'b0;
      o_card_rst <= 1'b0;
      o_card_c4 <= 1'b0;
      o_card_c8 <= 1'b0;
      o_card_io_out <= 1'b0;
      o_card_io_oe <= 1'b1;
      o_uart_sel <= 1'b0;
   end else if (i_ce) begin
      o_uart_sel <= aux_r[`SCC_AUX_UART];
      o_card_power <= pwr;
      o_card_clk <= pwr & sel_clk;
      o_card_rst <= pwr & contact_r[`SCC_CON_RST];
      o_card_c4 <= pwr & contact_r[`SCC_CON_C4];
      o_card_c8 <= pwr & contact_r[`SCC_CON_C8];
      // Open drain: the pin is only ever pulled low
      o_card_io_out <= 1'b0;
      o_card_io_oe <= ~(pwr & io_src);
   end
end

endmodule // scc_contact_status

//--- tb/scc_card_model.sv
// Smart card model: presence switch and the open-drain I/O line.
// Assumes the device pulls the line low with oe and the line has a pull-up.
`timescale 1ns/100ps

module scc_card_model (
   // Device side
   input wire logic i_io_oe,
   // Bench commands
   input wire logic i_pull_low,
   input wire logic i_inserted,
   // Card pins
   output logic o_io,
   output logic o_detect
);
   // Pull-up unless either party pulls low
   assign o_io = !(i_io_oe || i_pull_low);
   assign o_detect = i_inserted;
endmodule // scc_card_model

//--- tb/scc_cs_monitor.sv
// Checker for the card contact and status block.
// Assumes it is bound to scc_contact_status and sees only its ports.
`timescale 1ns/100ps

module scc_cs_monitor (
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire o_avs_waitrequest,
   input wire i_rx_done,
   input wire i_rx_parity_err,
   input wire i_rx_mode,
   input wire i_uart_io_out,
   input wire o_pe_indicate,
   input wire o_uart_sel,
   input wire o_card_power,
   input wire o_card_clk,
   input wire o_card_rst,
   input wire o_card_c4,
   input wire o_card_c8,
   input wire o_card_io_out,
   input wire o_card_io_oe
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce;
   endsequence
   sequence s_ack;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   AST_BUS_ACK: assert property (s_req |=> s_ack) else $error("bus ack late");
   AST_BUS_IDLE: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest |=>
      o_avs_waitrequest) else $error("ack without request");
   AST_PWR_OFF: assert property (!o_card_power |-> !o_card_rst && !o_card_c4 &&
      !o_card_c8 && !o_card_clk && o_card_io_oe) else $error("pins active unpowered");
   AST_IO_OD: assert property (o_card_io_out == 1'b0) else $error("io driven high");
   AST_UART_IO: assert property (i_ce && !i_uart_io_out |=>
      !(o_uart_sel && o_card_power) || o_card_io_oe) else $error("uart low not on pin");
   AST_PE_CAUSE: assert property (o_pe_indicate |->
      $past(i_rx_done && i_rx_parity_err && i_rx_mode)) else $error("parity indication uncaused");
   AST_CLK_HI: assert property ($rose(o_card_clk) |=> o_card_clk)
      else $error("runt high on card clock");
   AST_CLK_LO: assert property ($fell(o_card_clk) |=> !o_card_clk)
      else $error("runt low on card clock");
endmodule // scc_cs_monitor

bind scc_contact_status scc_cs_monitor i_mon (.i_mclk, .i_rst_n, .i_ce, .i_avs_read,
   .i_avs_write, .o_avs_waitrequest, .i_rx_done, .i_rx_parity_err, .i_rx_mode,
   .i_uart_io_out, .o_pe_indicate, .o_uart_sel, .o_card_power, .o_card_clk, .o_card_rst,
   .o_card_c4, .o_card_c8, .o_card_io_out, .o_card_io_oe);

//--- tb/scc_contact_status_tb.sv
// Testbench for the card contact and status block.
// Assumes an Avalon-MM slave with registered waitrequest.
`timescale 1ns/100ps

module scc_contact_status_tb;
   logic i_mclk = 0, i_rst_n = 0, rd = 0, wr = 0, pe = 0, rxm = 0, uo = 1, ovr = 0;
   logic vok = 1, ins = 1, pull = 0, xt = 0, ce = 1, det, io;
   logic [9:0] ad = 0;
   logic [7:0] wd = 0, evt = 0, v;
   logic [31:0] rdata;
   logic waitr, pei, usel, pwr, cclk, crst, c4, c8, iooe;
   int n_fail = 0, n_compared = 0, n;
   localparam logic [9:0] C = 10'h2b0, S = 10'h2b4, A = 10'h2c0;
   initial forever #2 i_mclk = ~i_mclk;
   initial forever #62.5 xt = ~xt;
   scc_contact_status i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce),
      .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata({24'h0, wd}),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitr), .i_tx_load(evt[0]),
      .i_txbuf_wr(evt[1]), .i_tx_done(evt[2]), .i_rx_done(evt[3]), .i_rx_buf_rd(evt[4]),
      .i_rx_parity_err(pe), .i_rx_mode(rxm), .i_uart_io_out(uo), .i_wt_timeout(evt[5]),
      .i_wt_reload(evt[6]), .o_pe_indicate(pei), .o_uart_sel(usel), .i_card_detect(det),
      .i_icc_over(ovr), .i_vcc_in_range(vok), .i_crystal_clock_clk(xt), .o_card_power(pwr),
      .o_card_clk(cclk), .o_card_rst(crst), .o_card_c4(c4), .o_card_c8(c8), .i_card_io(io),
      .o_card_io_out(), .o_card_io_oe(iooe));
   scc_card_model i_card (.i_io_oe(iooe), .i_pull_low(pull), .i_inserted(ins), .o_io(io),
      .o_detect(det));
   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge i_mclk);
   endtask
   task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      int t;
      t = 0;
      rd <= !w;
      wr <= w;
      ad <= a;
      wd <= d;
      do begin
         @(posedge i_mclk);
         t++;
         if (t > 20) begin
            n_fail++;
            end_of_test;
         end
      end while (waitr !== 1'b0);
      v = rdata[7:0];
      rd <= 0;
      wr <= 0;
      @(posedge i_mclk);
   endtask
   task ev(input int k);
      evt <= 8'h01 << k;
      @(posedge i_mclk);
      evt <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      bus(0, C, 0); chk(v, 8'h00);
      bus(0, S, 0); chk(v, 8'hd0);
      bus(1, 10'h000, 8'hff); bus(0, 10'h000, 0); chk(v, 8'h00);
      bus(1, C, 8'h40); bus(0, C, 0); chk(v, 8'h00);
   endtask
   task t_pins;
      bus(1, C, 8'h01); tick(2); chk(pwr, 1);
      bus(1, C, 8'h33); tick(2); chk({c8, c4, crst}, 8'h07);
      bus(1, C, 8'h01); tick(2); chk({c8, c4, crst}, 8'h00);
      bus(1, C, 8'h32); tick(2); chk({pwr, c8, c4, crst}, 8'h00);
   endtask
   task t_clk;
      logic p;
      bus(1, C, 8'h05); tick(6); chk(cclk, 1);
      bus(1, C, 8'h01); tick(6); chk(cclk, 0);
      bus(1, C, 8'h81);
      n = 0;
      p = cclk;
      repeat (250) begin
         @(posedge i_mclk);
         if (cclk && !p) n++;
         p = cclk;
      end
      chk(n > 5, 1);
      bus(1, C, 8'h01); tick(40); chk(cclk, 0);
   endtask
   task t_io;
      bus(1, C, 8'h09); tick(4); chk(iooe, 0);
      bus(0, C, 0); chk(v[3], 1);
      pull <= 1; tick(4); bus(0, C, 0); chk(v[3], 0);
      pull <= 0; bus(1, C, 8'h01); tick(2); chk(iooe, 1);
      bus(1, A, 8'h08); tick(2); chk(usel, 1);
      uo <= 0; tick(3); chk(iooe, 1);
      uo <= 1; tick(3); chk(iooe, 0);
      bus(1, A, 8'h00); bus(1, C, 8'h00);
   endtask
   task t_flags;
      ev(1); bus(0, S, 0); chk(v[7], 0);
      ev(0); bus(0, S, 0); chk(v[7], 1);
      ev(2); bus(0, S, 0); chk(v[2], 1);
      bus(1, S, 8'hfb); bus(0, S, 0); chk(v[2], 0);
      ev(3); bus(0, S, 0); chk(v[1], 1);
      ev(4); bus(0, S, 0); chk(v[1], 0);
      ev(5); bus(0, S, 0); chk(v[3], 1);
      ev(6); bus(0, S, 0); chk(v[3], 0);
      ovr <= 1; ins <= 0; tick(4); bus(0, S, 0); chk(v[6:5], 8'h01);
      ovr <= 0; ins <= 1; vok <= 0; tick(4); bus(0, S, 0); chk(v[6:4], 8'h04);
      vok <= 1;
   endtask
   task t_parity;
      bus(1, A, 8'h0a);
      rxm <= 1;
      pe <= 1;
      n = 0;
      repeat (3) begin
         ev(3);
         @(posedge i_mclk);
         if (pei === 1'b1) n++;
      end
      chk(n[7:0], 8'h03);
      bus(0, S, 0); chk(v[0], 0);
      ev(3); bus(0, S, 0); chk(v[0], 1);
      bus(1, S, 8'hfe); bus(0, S, 0); chk(v[0], 0);
      bus(1, A, 8'h00); ev(3); bus(0, S, 0); chk(v[0], 1);
      bus(1, S, 8'hfe); bus(1, A, 8'h0a); rxm <= 0;
      ev(3); bus(0, S, 0); chk(v[0], 1);
      bus(1, A, 8'h00);
      pe <= 0;
      rxm <= 0;
   endtask
   task t_ce_rst;
      ce <= 0; ev(2); ce <= 1; bus(0, S, 0); chk(v[2], 0);
      ev(2); bus(0, S, 0); chk(v[2], 1);
      bus(1, C, 8'h33); ev(1); i_rst_n <= 0; tick(2); chk({pwr, c8, c4, crst}, 8'h00);
      i_rst_n <= 1; tick(4); bus(0, C, 0); chk(v, 8'h00);
      bus(0, S, 0); chk(v, 8'hd0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(12);
      i_rst_n <= 1;
      @(posedge i_mclk);
      t_reset;
      t_pins;
      t_clk;
      t_io;
      t_flags;
      t_parity;
      t_ce_rst;
      end_of_test;
   end
endmodule // scc_contact_status_tb
